// File: inc/sar_pkg.sv
// Shared constants and types for the converter control block
package sar_pkg;
  localparam int RES_BITS = 10;
  localparam int BUS_BITS = 8;
  localparam int PAD_BITS = BUS_BITS - 2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ONESHOT_NS = 400;
  localparam int ONESHOT_CYCLES_RAW = ONESHOT_NS / CLK_PERIOD_NS;
  localparam int ONESHOT_CYCLES = (ONESHOT_CYCLES_RAW < 1) ? 1 : ONESHOT_CYCLES_RAW;
  localparam int CONV_CYCLES = 80;
  localparam int BIT_CYCLES = CONV_CYCLES / RES_BITS;
  localparam int PHASE_W = 3;
  localparam int CODE_COUNT = 1024;
  localparam logic [PHASE_W-1:0] PHASE_SAMPLE_POS = 3'h0;
  localparam logic [PHASE_W-1:0] PHASE_SAMPLE_NEG = 3'h4;
  localparam logic [PHASE_W-1:0] PHASE_DECIDE = 3'h7;
  localparam logic [PHASE_W-1:0] PHASE_STEP = 3'h1;
  localparam logic [RES_BITS-1:0] RESULT_RESET = 10'h000;
  localparam logic [RES_BITS-1:0] MARKER_INIT = 10'h200;
  localparam logic [PAD_BITS-1:0] LOW_BYTE_PAD = 6'h00;
  localparam logic [BUS_BITS-1:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_ARM = 2'b10,
    ST_CONV = 2'b11
  } conv_state_t;
endpackage

// File: src/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb begin
    nxt_st.meta = i_async;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff <= {RESET_VAL, RESET_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.sync;
endmodule

// File: src/pulse_stretch.sv
// Retriggerable one-shot of fixed length in clock cycles
`timescale 1ns/1ps
module pulse_stretch #(
  parameter int LEN = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_trigger,
  output logic o_active
);
  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LOAD = CW'(LEN - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic active;
  } shot_state_t;

  shot_state_t st_ff;
  shot_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_trigger) begin
      nxt_st.count = LOAD;
      nxt_st.active = 1'b1;
    end else if (st_ff.count != '0) begin
      nxt_st.count = st_ff.count - ONE;
    end else begin
      nxt_st.active = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_active = st_ff.active;
endmodule

// File: src/sar_adc_host_control.sv
// Successive-approximation control and byte-wide host interface
`timescale 1ns/1ps
module sar_adc_host_control
  import sar_pkg::*;
#(
  parameter int RES = sar_pkg::RES_BITS,
  parameter int SET_PULSE_CYCLES = sar_pkg::ONESHOT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic i_comp_high,
  output logic [sar_pkg::BUS_BITS-1:0] o_data,
  output logic o_data_oe_n,
  output logic o_conversion_done_n,
  output logic [sar_pkg::RES_BITS-1:0] o_dac_code,
  output logic o_sample_pos,
  output logic o_sample_neg
);
  import sar_pkg::*;

  typedef struct packed {
    conv_state_t state;
    logic [PHASE_W-1:0] phase;
    logic start_capture_stage;
    logic [RES_BITS-1:0] marker;
    logic [RES_BITS-1:0] sar;
    logic [RES_BITS-1:0] result;
    logic result_transfer;
    logic eoc;
    logic byte_sel;
    logic rd_act_d;
    logic [BUS_BITS-1:0] data;
    logic data_oe_n;
    logic done_n;
    logic [RES_BITS-1:0] dac;
    logic samp_pos;
    logic samp_neg;
  } ctrl_state_t;

  ctrl_state_t st_ff;
  ctrl_state_t nxt_st;

  logic cs_s;
  logic wr_s;
  logic rd_s;
  logic comp_s;
  logic set_act;
  logic rd_act;
  logic start_clear_gate;
  logic transfer_fall;
  logic set_pulse;
  logic [RES_BITS-1:0] sar_step;

  // Pin inputs synchronised before use
  pin_sync #(
    .W(4),
    .RESET_VAL(4'hE)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async({i_cs_n, i_wr_n, i_rd_n, i_comp_high}),
    .o_sync({cs_s, wr_s, rd_s, comp_s})
  );

  // Done-flag set pulse
  pulse_stretch #(
    .LEN(SET_PULSE_CYCLES)
  ) u_set_shot (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_trigger(transfer_fall),
    .o_active(set_pulse)
  );

  assign set_act = ~cs_s & ~wr_s;
  assign rd_act = ~cs_s & ~rd_s;
  assign start_clear_gate = st_ff.start_capture_stage & (st_ff.phase == PHASE_DECIDE);
  assign transfer_fall = st_ff.result_transfer & ~nxt_st.result_transfer;

  // Decision for the bit under test; a low comparator keeps it zero
  assign sar_step = comp_s ? (st_ff.sar | st_ff.marker) : st_ff.sar;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.phase = st_ff.phase + PHASE_STEP;
    nxt_st.result_transfer = 1'b0;
    nxt_st.rd_act_d = rd_act;

    case (st_ff.state)
      ST_IDLE: begin
        nxt_st.state = ST_IDLE;
      end
      ST_HOLD: begin
        if (!set_act) begin
          nxt_st.state = ST_ARM;
        end
      end
      ST_ARM: begin
        if (start_clear_gate) begin
          nxt_st.state = ST_CONV;
          nxt_st.start_capture_stage = 1'b0;
          nxt_st.marker = MARKER_INIT;
        end
      end
      ST_CONV: begin
        if (st_ff.phase == PHASE_DECIDE) begin
          nxt_st.sar = sar_step;
          nxt_st.marker = st_ff.marker >> 1;
          if (st_ff.marker[0]) begin
            nxt_st.result = sar_step;
            nxt_st.result_transfer = 1'b1;
            nxt_st.state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase

    // Start request overrides state, marker and sar; a result captured in the same cycle is still stored and transferred
    if (set_act) begin
      nxt_st.state = ST_HOLD;
      nxt_st.start_capture_stage = 1'b1;
      nxt_st.marker = '0;
      nxt_st.sar = '0;
    end

    // Done flag, set wins over any clear
    if (set_pulse) begin
      nxt_st.eoc = 1'b1;
    end else if (set_act || rd_act) begin
      nxt_st.eoc = 1'b0;
    end
    nxt_st.done_n = ~nxt_st.eoc;

    // Byte sequencing across two reads
    if (set_act || nxt_st.result_transfer) begin
      nxt_st.byte_sel = 1'b0;
    end else if (st_ff.rd_act_d && !rd_act) begin
      nxt_st.byte_sel = ~st_ff.byte_sel;
    end
    if (nxt_st.byte_sel) begin
      nxt_st.data = {nxt_st.result[1:0], LOW_BYTE_PAD};
    end else begin
      nxt_st.data = nxt_st.result[RES_BITS-1:2];
    end
    nxt_st.data_oe_n = ~rd_act;

    // Trial code and sample strobes, half a bit period apart
    nxt_st.dac = nxt_st.sar | nxt_st.marker;
    nxt_st.samp_pos = (nxt_st.state == ST_CONV) && (nxt_st.phase == PHASE_SAMPLE_POS);
    nxt_st.samp_neg = (nxt_st.state == ST_CONV) && (nxt_st.phase == PHASE_SAMPLE_NEG);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff.state <= ST_IDLE;
      st_ff.phase <= '0;
      st_ff.start_capture_stage <= 1'b0;
      st_ff.marker <= '0;
      st_ff.sar <= '0;
      st_ff.result <= RESULT_RESET;
      st_ff.result_transfer <= 1'b0;
      st_ff.eoc <= 1'b0;
      st_ff.byte_sel <= 1'b0;
      st_ff.rd_act_d <= 1'b0;
      st_ff.data <= DATA_RESET;
      st_ff.data_oe_n <= 1'b1;
      st_ff.done_n <= 1'b1;
      st_ff.dac <= '0;
      st_ff.samp_pos <= 1'b0;
      st_ff.samp_neg <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_data = st_ff.data;
  assign o_data_oe_n = st_ff.data_oe_n;
  assign o_conversion_done_n = st_ff.done_n;
  assign o_dac_code = st_ff.dac;
  assign o_sample_pos = st_ff.samp_pos;
  assign o_sample_neg = st_ff.samp_neg;
endmodule

// File: tb/sar_adc_host_control_properties.sv
// Port checks for the converter control block
`timescale 1ns/1ps
module sar_checker
  import sar_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic o_data_oe_n,
  input wire logic o_conversion_done_n,
  input wire logic [sar_pkg::RES_BITS-1:0] o_dac_code,
  input wire logic o_sample_pos,
  input wire logic o_sample_neg
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence rd_held;
    (!i_cs_n && !i_rd_n) [*4];
  endsequence
  sequence wr_held;
    (!i_cs_n && !i_wr_n) [*4];
  endsequence
  sequence leave_idle;
    $past(o_dac_code) == RESULT_RESET && o_dac_code != RESULT_RESET;
  endsequence
  a_read_enables: assert property (rd_held |=> !o_data_oe_n)
    else $error("data outputs not enabled by read");
  a_idle_floats: assert property (i_cs_n [*5] |=> o_data_oe_n)
    else $error("data outputs enabled without select");
  a_hold_reset: assert property (wr_held |=> o_dac_code == RESULT_RESET && !o_sample_pos)
    else $error("conversion runs while start held");
  a_start_clears: assert property (wr_held |-> ##[1:8] o_conversion_done_n)
    else $error("done flag not cleared by start");
  a_msb_first: assert property (leave_idle |-> o_dac_code == MARKER_INIT)
    else $error("first trial is not the top bit");
  a_conv_time: assert property (leave_idle |-> ##[76:90] $fell(o_conversion_done_n))
    else $error("done flag not set in conversion time");
  a_sample_gap: assert property (o_sample_pos && i_wr_n ##1 i_wr_n [*3] |-> ##1 o_sample_neg)
    else $error("negative sample not half period later");
  a_set_wins: assert property ($fell(o_conversion_done_n) |-> (!o_conversion_done_n) [*6])
    else $error("done pulse shorter than set pulse");
endmodule
bind sar_adc_host_control sar_checker chk_u (.i_clk, .i_rstn, .i_cs_n, .i_wr_n, .i_rd_n, .o_data_oe_n,
  .o_conversion_done_n, .o_dac_code, .o_sample_pos, .o_sample_neg);

// File: tb/comp_model.sv
// Comparator front end answering trial codes
`timescale 1ns/1ps
module comp_model (
  input wire logic i_clk,
  input wire logic [9:0] i_dac_code,
  input wire logic signed [11:0] i_diff,
  output logic o_comp_high
);
  initial o_comp_high = 1'b0;
  always @(posedge i_clk) o_comp_high <= (i_diff >= $signed({2'b00, i_dac_code}));
endmodule

// File: tb/tb_sar_adc_host_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_sar_adc_host_control;
  import sar_pkg::*;
  logic i_clk, i_rstn, i_cs_n, i_wr_n, i_rd_n, comp, o_data_oe_n, o_conversion_done_n, sp, sn;
  logic [BUS_BITS-1:0] o_data;
  logic [RES_BITS-1:0] dac;
  logic signed [11:0] diff;
  int errors, tests_run, cycles, seed, exp_q[$], v, k, n, p;
  sar_adc_host_control dut_u (.i_clk, .i_rstn, .i_cs_n, .i_wr_n, .i_rd_n, .i_comp_high(comp), .o_data,
    .o_data_oe_n, .o_conversion_done_n, .o_dac_code(dac), .o_sample_pos(sp), .o_sample_neg(sn));
  comp_model cmp_u (.i_clk, .i_dac_code(dac), .i_diff(diff), .o_comp_high(comp));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic cyc(int c);
    repeat (c) @(posedge i_clk);
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test;
    end
  end
  task automatic wait_done;
    n = 0;
    while (o_conversion_done_n !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic rd(logic [7:0] e);
    i_cs_n <= 1'b0;
    i_rd_n <= 1'b0;
    cyc(5);
    chk("oe", 8'h00, o_data_oe_n);
    chk("done_rd", 8'h01, o_conversion_done_n);
    chk("byte", e, o_data);
    i_cs_n <= 1'b1;
    i_rd_n <= 1'b1;
    cyc(5);
  endtask
  task automatic conv(int a, int b, int w);
    diff <= 12'(a - b);
    exp_q.push_back(a > b ? a - b : 0);
    i_cs_n <= 1'b0;
    i_wr_n <= 1'b0;
    cyc(w);
    i_cs_n <= 1'b1;
    i_wr_n <= 1'b1;
    wait_done;
    chk("conv_time", 8'h01, n >= 80 && n <= 100);
    cyc(12);
    chk("done_sticky", 8'h00, o_conversion_done_n);
    v = exp_q.pop_front();
    rd(v[9:2]);
    rd({v[1:0], LOW_BYTE_PAD});
    rd(v[9:2]);
  endtask
  initial begin
    seed = 32'h0fb65204;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    diff = '0;
    i_rstn = 1'b0;
    i_cs_n = 1'b1;
    i_wr_n = 1'b1;
    i_rd_n = 1'b1;
    cyc(10);
    i_rstn <= 1'b1;
    cyc(2);
    conv(1023, 0, 4);
    conv(0, 0, 3);
    conv(300, 700, 9);
    conv(512, 511, 1);
    for (k = 0; k < 6; k++) begin
      conv({$random(seed)} % 1024, {$random(seed)} % 1024, {$random(seed)} % 12 + 1);
    end
    diff <= 12'sd77;
    i_cs_n <= 1'b0;
    i_wr_n <= 1'b0;
    cyc(4);
    i_wr_n <= 1'b1;
    i_rd_n <= 1'b0;
    wait_done;
    chk("done_pulse", 8'h00, o_conversion_done_n);
    cyc(20);
    chk("done_clr", 8'h01, o_conversion_done_n);
    chk("held_byte", 8'h13, o_data);
    i_cs_n <= 1'b1;
    i_rd_n <= 1'b1;
    cyc(5);
    // Free running: select held low, write strobe follows the done pin
    diff <= 12'sd600;
    i_cs_n <= 1'b0;
    i_wr_n <= 1'b0;
    cyc(4);
    n = 0;
    p = 1;
    for (k = 0; k < 500 && n < 3; k++) begin
      i_wr_n <= o_conversion_done_n;
      if (p == 1 && o_conversion_done_n === 1'b0) n++;
      p = o_conversion_done_n;
      cyc(1);
    end
    chk("free_runs", 8'h03, 8'(n));
    v = 600;
    chk("free_byte", v[9:2], o_data);
    i_cs_n <= 1'b1;
    i_wr_n <= 1'b1;
    cyc(5);
    end_of_test;
  end
endmodule
